//--- design/rbc_pkg.sv
// Constants, types and register map of the RAM back-up and clock control.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
// Function
// - Reset scrambles group, aux pointer, temp byte
// - Low enabled wakeup port returns from back-up
// - Back-up only when power-off follows arm
// - Back-up scrambles all five pointer registers
// - Watchdog re-armed on return; disable+restart stops
// - Control bit 3 clear disables shared pin
// - No back-up when clocked externally
// - Oscillator select honoured once only
// - Selection stops other and on-chip oscillators
// - Stabilisation wait timed by on-chip oscillator until a source is selected, then by clk
package rbc_pkg;
  localparam int          CLK_MHZ       = 200;
  localparam logic [7:0]  ADDR_CMD      = 8'h00;
  localparam logic [7:0]  ADDR_WAKE_SEL = 8'h04;
  localparam logic [7:0]  ADDR_EXT_INT  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_WORK     = 8'h10;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  localparam logic [3:0]  CMD_ARM       = 4'h1;
  localparam logic [3:0]  CMD_POWER_OFF = 4'h2;
  localparam logic [3:0]  CMD_INT_DIS   = 4'h3;
  localparam logic [3:0]  CMD_INT_EN    = 4'h4;
  localparam logic [3:0]  CMD_WDT_DIS   = 4'h5;
  localparam logic [3:0]  CMD_WDT_RST   = 4'h6;
  localparam logic [3:0]  CMD_CER_SEL   = 4'h7;
  localparam logic [3:0]  CMD_RC_SEL    = 4'h8;

  localparam int          EXT_INT_W       = 4;
  localparam int          EXT_PIN_EN_BIT  = 3;
  localparam int          EXT_EDGE_BIT    = 2;
  localparam logic [3:0]  EXT_INT_RST     = 4'h0;
  localparam int          WAKE_W_DEF      = 12;
  localparam int          SHARED_IDX_DEF  = 7;

  localparam logic [1:0]  OSC_NONE = 2'h0;
  localparam logic [1:0]  OSC_CER  = 2'h1;
  localparam logic [1:0]  OSC_RC   = 2'h2;

  localparam int          WORK_W       = 21;
  localparam int          GRP_LSB      = 0;
  localparam int          GRP_W        = 2;
  localparam int          FILE_LSB     = 2;
  localparam int          FILE_W       = 4;
  localparam int          DIGIT_LSB    = 6;
  localparam int          DIGIT_W      = 4;
  localparam int          AUX_LSB      = 10;
  localparam int          AUX_W        = 3;
  localparam int          TEMP_LSB     = 13;
  localparam int          TEMP_W       = 8;
  localparam logic [20:0] WORK_RST     = 21'h000000;

  localparam int          ST_LSB       = 0;
  localparam int          OSC_LSB      = 3;
  localparam int          WDT_BIT      = 5;
  localparam int          INTEN_BIT    = 6;
  localparam int          EXTCLK_BIT   = 7;
  localparam int          ARM_BIT      = 8;

  localparam logic [15:0] LFSR_SEED    = 16'hace1;
  localparam int          STAB_TICKS_DEF = 16;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_BACKUP = 3'b010,
    ST_STAB   = 3'b100
  } rbc_state_t;
endpackage

//--- design/rbc_stab_if.sv
// Start, tick and busy lines between the sequencer and its stabilisation timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rbc_stab_if;
  logic start;
  logic tick;
  logic busy;
  modport ctrl  (output start, output tick, input busy);
  modport timer (input start, input tick, output busy);
endinterface
`default_nettype wire

//--- design/rbc_stab_timer.sv
// Oscillation stabilisation wait counter; counts tick pulses after start.
// Assumes tick is a one-cycle pulse already in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module rbc_stab_timer
  import rbc_pkg::*;
#(
  parameter int TICKS = STAB_TICKS_DEF
) (
  input  wire logic   clk,
  input  wire logic   reset,
  rbc_stab_if.timer   st
);
  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LOAD = CW'(TICKS);
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  if (TICKS < 1) begin : g_chk
    $error("rbc_stab_timer: TICKS must be at least 1");
  end
  assign st.busy = busy_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (st.start) begin
      cnt_q  <= LOAD;
      busy_q <= 1'b1;
    end else if (busy_q && st.tick) begin
      cnt_q  <= cnt_q - CW'(1);
      busy_q <= (cnt_q != CW'(1));
    end
  end
endmodule
`default_nettype wire

//--- design/rbc_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the levels are quasi-static relative to clk.
`timescale 1ns/1ps
`default_nettype none
module rbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  if (W < 1) begin : g_chk
    $error("rbc_sync: W must be at least 1");
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- design/rbc_top.sv
// RAM back-up entry, key-on wakeup and oscillator selection controller.
// Assumes commands arrive as AXI4-Lite writes from the core on clk; all
// pin inputs are asynchronous and are synchronised here.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rbc_top
  import rbc_pkg::*;
#(
  parameter int WAKE_W     = WAKE_W_DEF,
  parameter int SHARED_IDX = SHARED_IDX_DEF,
  parameter int STAB_TICKS = STAB_TICKS_DEF
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [WAKE_W-1:0] wake_port_pin,
  input  wire logic              onchip_osc_pin,
  input  wire logic              oscillator_input_is_ext,
  output logic                   sys_clk_en,
  output logic                   cpu_run,
  output logic                   backup_active,
  output logic                   ceramic_osc_en,
  output logic                   rc_osc_en,
  output logic                   onchip_osc_en,
  output logic                   wdt_enable,
  output logic                   wdt_restart,
  output logic                   int_enable,
  output logic                   wake_shared_pin_in
);
  if (WAKE_W < 1 || WAKE_W > 32 || SHARED_IDX >= WAKE_W) begin : g_chk
    $error("rbc_top: wakeup width or shared index out of range");
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Scramble stands in for undefined contents so reads never show X
  function automatic logic [WORK_W-1:0] scramble(
      input logic [WORK_W-1:0] w, input logic [15:0] rnd,
      input logic all_regs);
    logic [WORK_W-1:0] r;
    r = w;
    r[GRP_LSB +: GRP_W]   = rnd[1:0];
    r[AUX_LSB +: AUX_W]   = rnd[4:2];
    r[TEMP_LSB +: TEMP_W] = rnd[15:8];
    if (all_regs) begin
      r[FILE_LSB +: FILE_W]   = rnd[8:5];
      r[DIGIT_LSB +: DIGIT_W] = rnd[12:9];
    end
    return r;
  endfunction

  rbc_state_t            state_q;
  rbc_state_t            state_d;
  logic [7:0]            awaddr_q;
  logic                  aw_have_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  w_have_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  rvalid_q;
  logic [WAKE_W-1:0]     wake_sel_q;
  logic [EXT_INT_W-1:0]  ext_int_q;
  logic [WORK_W-1:0]     work_q;
  logic [15:0]           lfsr_q;
  logic [1:0]            osc_sel_q;
  logic                  arm_q;
  logic                  wdt_dis_pend_q;
  logic                  wdt_en_q;
  logic                  wdt_rst_q;
  logic                  int_en_q;
  logic                  ext_clk_q;
  logic                  strap_taken_q;
  logic                  start_q;
  logic                  osc_prev_q;
  logic [WAKE_W-1:0]     wake_sync;
  logic                  osc_sync;
  logic                  strap_sync;

  rbc_stab_if stab ();

  rbc_sync #(.W(WAKE_W + 2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({oscillator_input_is_ext, onchip_osc_pin, wake_port_pin}),
    .q     ({strap_sync, osc_sync, wake_sync})
  );

  rbc_stab_timer #(.TICKS(STAB_TICKS)) u_timer (
    .clk   (clk),
    .reset (reset),
    .st    (stab.timer)
  );

  wire do_write   = aw_have_q && w_have_q && !bvalid_q;
  wire wr_cmd     = awaddr_q == ADDR_CMD;
  wire wr_wake    = awaddr_q == ADDR_WAKE_SEL;
  wire wr_ext     = awaddr_q == ADDR_EXT_INT;
  wire wr_work    = awaddr_q == ADDR_WORK;
  wire wr_ok      = wr_cmd || wr_wake || wr_ext || wr_work ||
                    awaddr_q == ADDR_STATUS;
  wire rd_hs      = s_axi_arvalid && !rvalid_q;
  wire [31:0] wr_merged = merge_strb(32'h0, wdata_q, wstrb_q);
  wire [31:0] work_merged = merge_strb(32'(work_q), wdata_q, wstrb_q);

  // Commands only execute while the core is running
  wire        cmd_fire = do_write && wr_cmd && wstrb_q[0] &&
                         state_q == ST_RUN;
  wire [3:0]  cmd      = wdata_q[3:0];
  wire        run      = state_q == ST_RUN;

  // Shared pin only reaches interrupt logic while its input is enabled
  wire pin_en   = ext_int_q[EXT_PIN_EN_BIT];
  wire wake_req = |(wake_sel_q & ~wake_sync);
  wire po_entry = cmd_fire && cmd == CMD_POWER_OFF && arm_q &&
                  !ext_clk_q;
  wire back_leave = state_q == ST_BACKUP && wake_req;
  wire osc_rise   = osc_sync && !osc_prev_q;
  // Before selection the wait runs on on-chip ticks; once that oscillator
  // is stopped the selected source, i.e. clk, paces it instead.
  wire stab_tick  = (osc_sel_q == OSC_NONE) ? osc_rise : 1'b1;
  wire stab_done  = state_q == ST_STAB && !start_q && !stab.busy;

  assign stab.start = start_q;
  assign stab.tick  = stab_tick;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (po_entry) begin
          state_d = ST_BACKUP;
        end
      end
      ST_BACKUP: begin
        if (back_leave) begin
          state_d = ST_STAB;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_STAB;
    endcase
  end

  wire [31:0] status_w = {23'h0, arm_q, ext_clk_q, int_en_q, wdt_en_q,
                          osc_sel_q, state_q};
  wire        rd_ok    = s_axi_araddr == ADDR_CMD ||
                         s_axi_araddr == ADDR_WAKE_SEL ||
                         s_axi_araddr == ADDR_EXT_INT ||
                         s_axi_araddr == ADDR_STATUS ||
                         s_axi_araddr == ADDR_WORK;
  wire [31:0] rd_mux =
      (s_axi_araddr == ADDR_WAKE_SEL) ? 32'(wake_sel_q) :
      (s_axi_araddr == ADDR_EXT_INT)  ? 32'(ext_int_q)  :
      (s_axi_araddr == ADDR_STATUS)   ? status_w        :
      (s_axi_araddr == ADDR_WORK)     ? 32'(work_q)     : 32'h0;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ST_STAB;
      start_q    <= 1'b1;
      osc_prev_q <= 1'b0;
      lfsr_q     <= LFSR_SEED;
    end else begin
      state_q    <= state_d;
      start_q    <= back_leave;
      osc_prev_q <= osc_sync;
      lfsr_q     <= {lfsr_q[14:0],
                     lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // Strap is static on a board; following it keeps the settled level
  // rather than the flushed synchroniser value seen just after reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_clk_q     <= 1'b0;
      strap_taken_q <= 1'b0;
    end else begin
      ext_clk_q     <= strap_sync;
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_sel_q <= '0;
      ext_int_q  <= EXT_INT_RST;
    end else if (do_write && wr_wake) begin
      wake_sel_q <= wr_merged[WAKE_W-1:0];
    end else if (do_write && wr_ext) begin
      ext_int_q  <= wr_merged[EXT_INT_W-1:0];
    end
  end

  // Group, aux and temp have no defined value after reset; all five fields after back-up
  always_ff @(posedge clk) begin
    if (reset) begin
      work_q <= WORK_RST;
    end else if (strap_taken_q == 1'b0) begin
      work_q <= scramble(work_q, lfsr_q, 1'b0);
    end else if (back_leave) begin
      work_q <= scramble(work_q, lfsr_q, 1'b1);
    end else if (do_write && wr_work) begin
      work_q <= work_merged[WORK_W-1:0];
    end
  end

  // Arm must be the command just before power-off; any other breaks it
  always_ff @(posedge clk) begin
    if (reset) begin
      arm_q <= 1'b0;
    end else if (cmd_fire) begin
      arm_q <= cmd == CMD_ARM;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      int_en_q <= 1'b0;
    end else if (cmd_fire && cmd == CMD_INT_DIS) begin
      int_en_q <= 1'b0;
    end else if (cmd_fire && cmd == CMD_INT_EN) begin
      int_en_q <= 1'b1;
    end
  end

  // Watchdog comes back on at every return, so software must repeat
  // the disable/restart pair each time.
  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_en_q       <= 1'b1;
      wdt_dis_pend_q <= 1'b0;
      wdt_rst_q      <= 1'b0;
    end else begin
      wdt_rst_q <= cmd_fire && cmd == CMD_WDT_RST;
      if (back_leave) begin
        wdt_en_q       <= 1'b1;
        wdt_dis_pend_q <= 1'b0;
      end else if (cmd_fire) begin
        wdt_dis_pend_q <= cmd == CMD_WDT_DIS;
        if (cmd == CMD_WDT_RST && wdt_dis_pend_q) begin
          wdt_en_q <= 1'b0;
        end
      end
    end
  end

  // First selection wins; later ones are silently dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_sel_q <= OSC_NONE;
    end else if (cmd_fire && osc_sel_q == OSC_NONE) begin
      if (cmd == CMD_CER_SEL) begin
        osc_sel_q <= OSC_CER;
      end else if (cmd == CMD_RC_SEL) begin
        osc_sel_q <= OSC_RC;
      end
    end
  end

  // Back-up gates core clock and execution; RAM simply keeps its state
  assign sys_clk_en     = state_q != ST_BACKUP;
  assign cpu_run        = run;
  assign backup_active  = state_q == ST_BACKUP;
  assign ceramic_osc_en = osc_sel_q == OSC_CER && sys_clk_en;
  assign rc_osc_en      = osc_sel_q == OSC_RC && sys_clk_en;
  assign onchip_osc_en  = osc_sel_q == OSC_NONE;
  assign wdt_enable     = wdt_en_q;
  assign wdt_restart    = wdt_rst_q;
  assign int_enable     = int_en_q;
  assign wake_shared_pin_in = wake_sync[SHARED_IDX] && pin_en;
endmodule
`default_nettype wire

//--- tb/rbc_top_properties.sv
// Checker for the back-up sequencer, watching top-level ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rbc_top_properties #(
  parameter int WAKE_W = 12
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic [WAKE_W-1:0] wake_port_pin,
  input  wire logic              oscillator_input_is_ext,
  input  wire logic              sys_clk_en,
  input  wire logic              cpu_run,
  input  wire logic              backup_active,
  input  wire logic              ceramic_osc_en,
  input  wire logic              rc_osc_en,
  input  wire logic              onchip_osc_en,
  input  wire logic              wdt_enable,
  input  wire logic              wdt_restart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_BACKUP_HALT: assert property (
    backup_active |-> !sys_clk_en && !cpu_run && !ceramic_osc_en &&
    !rc_osc_en) else $error("clock alive in back-up");
  AST_RUN_CLOCKED: assert property (
    cpu_run |-> sys_clk_en && !backup_active)
    else $error("run without clock");
  AST_ONE_SOURCE: assert property (
    !(ceramic_osc_en && rc_osc_en)) else $error("two sources enabled");
  AST_ONCHIP_STAYS_OFF: assert property (
    !onchip_osc_en |=> !onchip_osc_en)
    else $error("on-chip oscillator restarted");
  AST_SOURCE_HELD: assert property (
    !onchip_osc_en |-> backup_active || ceramic_osc_en || rc_osc_en)
    else $error("no source running");
  // Strap passes a two-flop synchroniser, so only a settled strap counts
  AST_EXT_NO_BACKUP: assert property (
    oscillator_input_is_ext && $past(oscillator_input_is_ext, 4) &&
    !backup_active |=> !backup_active)
    else $error("back-up on external clock");
  // Pin levels reach the state register three edges late
  AST_WAKE_NEEDS_LOW: assert property (
    $fell(backup_active) |-> !(&$past(wake_port_pin, 3)))
    else $error("return without low pin");
  AST_RETURN_WDT: assert property (
    $fell(backup_active) |-> wdt_enable && !cpu_run && sys_clk_en)
    else $error("return path wrong");
  AST_WDT_OFF_CAUSE: assert property (
    $fell(wdt_enable) |-> wdt_restart || $past(wdt_restart) ||
    $past(wdt_restart, 2)) else $error("watchdog off without restart");
  AST_RESTART_PULSE: assert property (
    wdt_restart |=> !wdt_restart) else $error("restart pulse too long");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  COV_ENTER: cover property ($rose(backup_active));
  COV_RETURN: cover property ($fell(backup_active));
  COV_WDT_OFF: cover property ($fell(wdt_enable));
  COV_RC: cover property ($rose(rc_osc_en));
endmodule
bind rbc_top rbc_top_properties #(.WAKE_W(WAKE_W)) u_props (
  .clk(clk), .reset(reset), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .wake_port_pin(wake_port_pin),
  .oscillator_input_is_ext(oscillator_input_is_ext),
  .sys_clk_en(sys_clk_en), .cpu_run(cpu_run), .backup_active(backup_active),
  .ceramic_osc_en(ceramic_osc_en), .rc_osc_en(rc_osc_en),
  .onchip_osc_en(onchip_osc_en), .wdt_enable(wdt_enable),
  .wdt_restart(wdt_restart));
`default_nettype wire

//--- tb/rbc_top_tb.sv
// Self-checking bench for rbc_top: AXI4-Lite master tasks plus scenarios.
// Assumes rbc_wake_model drives the wakeup pins and on-chip oscillator.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module rbc_top_tb;
  import rbc_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, strap = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, osc;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic [11:0] pin;
  logic        awready, wready, bvalid, arready, rvalid, sys_clk_en, cpu_run;
  logic        backup_active, cer_en, rc_en, onchip_en, wdt_en, wdt_rst;
  logic        int_en, shared_in;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  rbc_wake_model wm (.clk(clk), .pin(pin), .osc(osc));
  // Short stabilisation count keeps the returns quick
  rbc_top #(.STAB_TICKS(2)) dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_port_pin(pin),
    .onchip_osc_pin(osc), .oscillator_input_is_ext(strap),
    .sys_clk_en(sys_clk_en), .cpu_run(cpu_run),
    .backup_active(backup_active), .ceramic_osc_en(cer_en),
    .rc_osc_en(rc_en), .onchip_osc_en(onchip_en), .wdt_enable(wdt_en),
    .wdt_restart(wdt_rst), .int_enable(int_en),
    .wake_shared_pin_in(shared_in));

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) n_mismatch++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) n_mismatch++;
  endtask

  task automatic cmd(input logic [3:0] c);
    logic [1:0] r;
    axi_wr(ADDR_CMD, {28'h0, c}, r);
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_run();
    for (int i = 0; i < 500 && cpu_run !== 1'b1; i++) @(posedge clk);
    `CHK(cpu_run, 1'b1)
  endtask

  // Stopped on-chip oscillator must hold the wait open
  task automatic t_stab();
    logic [31:0] d;
    logic [1:0]  r;
    repeat (40) @(posedge clk);
    `CHK(cpu_run, 1'b0)
    wm.osc_run = 1'b1;
    wait_run();
    axi_rd(ADDR_STATUS, d, r);
    `CHK(d, 32'h00000021)
    `CHK(onchip_en, 1'b1)
    axi_rd(8'h20, d, r);
    `CHK(r, RESP_SLVERR)
  endtask

  // Software must load the working registers itself
  task automatic t_work(input logic [20:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(ADDR_WORK, {11'h0, v}, r);
    axi_rd(ADDR_WORK, d, r);
    `CHK(d, {11'h0, v})
  endtask

  task automatic t_shared();
    logic [1:0] r;
    axi_wr(ADDR_EXT_INT, 32'h8, r);
    repeat (4) @(posedge clk);
    `CHK(shared_in, 1'b1)
    axi_wr(ADDR_EXT_INT, 32'h0, r);
    repeat (4) @(posedge clk);
    `CHK(shared_in, 1'b0)
  endtask

  task automatic t_refuse();
    cmd(CMD_POWER_OFF);
    `CHK(backup_active, 1'b0)
    cmd(CMD_ARM);
    cmd(CMD_INT_DIS);
    cmd(CMD_POWER_OFF);
    `CHK(backup_active, 1'b0)
    strap <= 1'b1;
    repeat (6) @(posedge clk);
    cmd(CMD_ARM);
    cmd(CMD_POWER_OFF);
    `CHK(backup_active, 1'b0)
    strap <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_osc();
    logic [31:0] d;
    logic [1:0]  r;
    cmd(CMD_RC_SEL);
    `CHK({rc_en, cer_en, onchip_en}, 3'b100)
    cmd(CMD_CER_SEL);
    `CHK({rc_en, cer_en}, 2'b10)
    axi_rd(ADDR_STATUS, d, r);
    `CHK(d[4:3], OSC_RC)
  endtask

  task automatic t_backup();
    logic [1:0] r;
    axi_wr(ADDR_WAKE_SEL, 32'h8, r);
    cmd(CMD_WDT_DIS);
    cmd(CMD_WDT_RST);
    `CHK(wdt_en, 1'b0)
    cmd(CMD_INT_EN);
    `CHK(int_en, 1'b1)
    cmd(CMD_INT_DIS);
    `CHK(int_en, 1'b0)
    cmd(CMD_ARM);
    cmd(CMD_POWER_OFF);
    `CHK({backup_active, sys_clk_en, rc_en}, 3'b100)
    wm.press(5, 10);
    `CHK(backup_active, 1'b1)
    wm.press(3, 10);
    `CHK(backup_active, 1'b0)
    `CHK(wdt_en, 1'b1)
    wait_run();
    t_work(21'h1abcde);
  endtask

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    end_sim();
  end

  initial begin
    wm.osc_run = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_stab();
    t_work(21'h0f5a3c);
    t_shared();
    t_refuse();
    t_osc();
    t_backup();
    end_sim();
  end
endmodule
`default_nettype wire

//--- tb/rbc_wake_model.sv
// Partner model: key lines on the wakeup ports and the on-chip oscillator.
// Assumes the bench calls press() and sets osc_run by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module rbc_wake_model (
  input  wire logic        clk,
  output logic      [11:0] pin,
  output logic             osc
);
  logic       osc_run = 1'b1;
  logic [1:0] div_q   = 2'h0;
  // Keys idle high through pull-ups, so enabled ports sit high
  initial pin = 12'hfff;
  initial osc = 1'b0;
  // Free-running on-chip oscillator, far slower than clk
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (osc_run && div_q == 2'h3) osc <= ~osc;
  end
  task automatic press(input int idx, input int n);
    @(posedge clk);
    pin[idx] <= 1'b0;
    repeat (n) @(posedge clk);
    pin[idx] <= 1'b1;
  endtask
endmodule
`default_nettype wire
